// ### src/sse_ecc.v
// SECDED protected on-chip memory with APB control registers and debug access
`timescale 1ns/10ps
`include "sse_regs.vh"

module sse_ecc
#(
	parameter ADDR_W = 12,
	parameter APB_AW = 12
)
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [APB_AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire special_mode,
	input wire sys_req,
	input wire sys_we,
	input wire [1:0] sys_be,
	input wire [ADDR_W-1:0] sys_addr,
	input wire [15:0] sys_wdata,
	output reg sys_ack,
	output reg [15:0] sys_rdata,
	output reg sys_single_err,
	output reg sys_double_err,
	output reg ecc_ready,
	output reg single_error_irq
);

	localparam DEPTH = 1 << ADDR_W;
	// One-hot controller states
	localparam ST_INIT = 3'b001;
	localparam ST_IDLE = 3'b010;
	localparam ST_EVAL = 3'b100;

	// Storage: data in the low 16 bits, check bits above
	reg [21:0] mem [0:DEPTH-1];
	reg [21:0] mrd_q; // Registered read port
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [ADDR_W-1:0] init_cnt_q; // Walks every word during init
	reg ready_q; // Initialization done
	reg irq_en_q; // Single-error interrupt enable
	reg flag_q; // Sticky single-error flag
	reg [23:0] ptr_q; // Debug pointer, byte address
	reg [15:0] raw_q; // Debug raw data
	reg [5:0] chk_q; // Debug check bits
	reg cmd_rd_q; // Pending debug read
	reg cmd_wr_q; // Pending debug write
	reg rd_done_q; // Debug read finished
	reg spec_meta_q; // Special-mode pin, first stage
	reg spec_q; // Special-mode pin, safe to use
	// Latched operation
	reg op_dbg_q;
	reg op_we_q;
	reg [1:0] op_be_q;
	reg [ADDR_W-1:0] op_addr_q;
	reg [15:0] op_wdata_q;

	// Memory port controls
	reg mem_we;
	reg [ADDR_W-1:0] mem_addr;
	reg [21:0] mem_wdata;
	reg [15:0] merged; // Corrected old word with new bytes merged in
	wire [5:0] enc_check;
	wire [15:0] dec_fixed;
	wire dec_single;
	wire dec_double;

	// APB decode
	wire [3:0] idx = paddr[5:2];
	wire upper_zero = (paddr[APB_AW-1:6] == {(APB_AW-6){1'b0}});
	reg mapped;
	reg [7:0] rd_val;
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
	wire idle_go = state_q[1] & ~sys_ack;
	wire take_dbg = idle_go & (cmd_rd_q | cmd_wr_q);
	wire take_sys = idle_go & ~(cmd_rd_q | cmd_wr_q) & sys_req;
	wire eval_sbe = state_q[2] & ~op_dbg_q & dec_single & ~(op_we_q & (op_be_q == 2'b11));
	wire [ADDR_W-1:0] ptr_word = ptr_q[ADDR_W:1];

	// Shared codec: encodes the merged word and checks the fetched one
	sse_codec u_codec
	(
		.enc_data(merged),
		.enc_check(enc_check),
		.dec_data(mrd_q[15:0]),
		.dec_check(mrd_q[21:16]),
		.dec_fixed(dec_fixed),
		.dec_single(dec_single),
		.dec_double(dec_double)
	);

	// Byte merge over the corrected word; a full write ignores the old word
	always @*
	begin
		merged = dec_fixed;
		// With both enables set the old word is fully replaced
		if (op_be_q[0])
			merged[7:0] = op_wdata_q[7:0];
		if (op_be_q[1])
			merged[15:8] = op_wdata_q[15:8];
	end

	// Memory port mux and next state
	always @*
	begin
		state_d = state_q;
		mem_we = 1'b0;
		mem_addr = op_addr_q;
		mem_wdata = {enc_check, merged};
		case (state_q)
			ST_INIT:
			begin
				// Clear every word to zero data with its matching code
				mem_we = 1'b1;
				mem_addr = init_cnt_q;
				mem_wdata = 22'h000000;
				if (init_cnt_q == {ADDR_W{1'b1}})
					state_d = ST_IDLE;
			end
			ST_IDLE:
			begin
				mem_addr = sys_addr;
				if (take_dbg)
				begin
					mem_addr = ptr_word;
					if (cmd_wr_q)
					begin
						mem_we = 1'b1;
						mem_wdata = {chk_q, raw_q};
					end
					else
						state_d = ST_EVAL;
				end
				else if (take_sys)
					state_d = ST_EVAL;
			end
			ST_EVAL:
			begin
				// A partial write whose old word holds two flips is not stored; a full write is
				mem_we = ~op_dbg_q & op_we_q & ((op_be_q == 2'b11) | ~dec_double);
				state_d = ST_IDLE;
			end
			default:
				state_d = ST_INIT;
		endcase
	end

	// Memory array: write port and registered read, no reset by nature
	always @(posedge pclk)
	begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		mrd_q <= mem[mem_addr];
	end

	// Controller, system answer and operation latch
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= ST_INIT;
			init_cnt_q <= {ADDR_W{1'b0}};
			ready_q <= `SSE_RST_BIT;
			op_dbg_q <= 1'b0;
			op_we_q <= 1'b0;
			op_be_q <= 2'b00;
			op_addr_q <= {ADDR_W{1'b0}};
			op_wdata_q <= 16'h0000;
			sys_ack <= 1'b0;
			sys_rdata <= 16'h0000;
			sys_single_err <= 1'b0;
			sys_double_err <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			sys_ack <= 1'b0;
			sys_single_err <= 1'b0;
			sys_double_err <= 1'b0;
			if (state_q[0])
				init_cnt_q <= init_cnt_q + {{(ADDR_W-1){1'b0}}, 1'b1};
			if (state_q[0] && state_d[1])
				ready_q <= 1'b1;
			// Requests wait untaken while init runs: idle is reached only after it
			if (take_dbg || take_sys)
			begin
				op_dbg_q <= take_dbg;
				op_we_q <= take_sys & sys_we;
				op_be_q <= take_sys ? sys_be : 2'b00;
				op_addr_q <= take_dbg ? ptr_word : sys_addr;
				op_wdata_q <= sys_wdata;
			end
			// System answer one cycle after the fetch
			if (state_q[2] && !op_dbg_q)
			begin
				sys_ack <= 1'b1;
				sys_rdata <= dec_fixed;
				sys_single_err <= dec_single;
				sys_double_err <= dec_double;
			end
		end
	end

	// Software registers; hardware set beats a same-cycle clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_en_q <= `SSE_RST_BIT;
			flag_q <= `SSE_RST_BIT;
			ptr_q <= `SSE_RST_PTR;
			raw_q <= `SSE_RST_RAW;
			chk_q <= `SSE_RST_CHECK;
			cmd_rd_q <= `SSE_RST_BIT;
			cmd_wr_q <= `SSE_RST_BIT;
			rd_done_q <= `SSE_RST_BIT;
		end
		else
		begin
			if (apb_wr)
			begin
				case (idx)
					`SSE_IDX_IRQ_EN:
						irq_en_q <= pwdata[`SSE_IRQ_EN_BIT];
					`SSE_IDX_FLAG:
						if (pwdata[`SSE_FLAG_BIT])
							flag_q <= 1'b0;
					// Pointer bits outside the memory span are not kept
					`SSE_IDX_PTR_H:
						ptr_q[23:16] <= pwdata[7:0];
					`SSE_IDX_PTR_M:
						ptr_q[15:8] <= pwdata[7:0];
					`SSE_IDX_PTR_L:
						ptr_q[7:1] <= pwdata[7:1];
					`SSE_IDX_RAW_H:
						raw_q[15:8] <= pwdata[7:0];
					`SSE_IDX_RAW_L:
						raw_q[7:0] <= pwdata[7:0];
					`SSE_IDX_CHECK:
						chk_q <= pwdata[5:0];
					`SSE_IDX_CMD:
						// Commands only take effect in special mode
						if (spec_q)
						begin
							cmd_rd_q <= pwdata[`SSE_CMD_RD_BIT];
							cmd_wr_q <= pwdata[`SSE_CMD_WR_BIT] & ~pwdata[`SSE_CMD_RD_BIT];
							if (pwdata[`SSE_CMD_RD_BIT])
								rd_done_q <= 1'b0;
						end
					default:
						irq_en_q <= irq_en_q;
				endcase
			end
			// Drop bits that the memory span cannot address
			ptr_q[23:ADDR_W+1] <= {(23-ADDR_W){1'b0}};
			ptr_q[0] <= 1'b0;
			// Debug write completes in the cycle it is taken
			if (take_dbg && cmd_wr_q)
				cmd_wr_q <= 1'b0;
			// Debug read returns raw stored bits, no correction
			if (state_q[2] && op_dbg_q)
			begin
				raw_q <= mrd_q[15:0];
				chk_q <= mrd_q[21:16];
				cmd_rd_q <= 1'b0;
				rd_done_q <= 1'b1;
			end
			if (eval_sbe)
				flag_q <= 1'b1;
		end
	end

	// Read mux and decode of mapped offsets
	always @*
	begin
		rd_val = 8'h00;
		mapped = upper_zero & (paddr[1:0] == 2'b00);
		case (idx)
			`SSE_IDX_STAT:
				rd_val[`SSE_RDY_BIT] = ready_q;
			`SSE_IDX_IRQ_EN:
				rd_val[`SSE_IRQ_EN_BIT] = irq_en_q;
			`SSE_IDX_FLAG:
				rd_val[`SSE_FLAG_BIT] = flag_q;
			`SSE_IDX_PTR_H:
				rd_val = ptr_q[23:16];
			`SSE_IDX_PTR_M:
				rd_val = ptr_q[15:8];
			`SSE_IDX_PTR_L:
				rd_val = ptr_q[7:0];
			`SSE_IDX_RAW_H:
				rd_val = raw_q[15:8];
			`SSE_IDX_RAW_L:
				rd_val = raw_q[7:0];
			`SSE_IDX_CHECK:
				rd_val = {2'b00, chk_q};
			`SSE_IDX_CMD:
				rd_val = {rd_done_q, 5'h00, cmd_wr_q, cmd_rd_q};
			default:
				mapped = 1'b0;
		endcase
	end

	// APB answer: ready in the first cycle of the access phase, errors on holes
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~mapped;
			if (apb_setup && !pwrite && mapped)
				prdata <= {24'h000000, rd_val};
			else if (apb_setup)
				prdata <= 32'h00000000;
		end
	end

	// Status and interrupt outputs; the special-mode pin passes two flops before use
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			spec_meta_q <= 1'b0;
			spec_q <= 1'b0;
			ecc_ready <= 1'b0;
			single_error_irq <= 1'b0;
		end
		else
		begin
			spec_meta_q <= special_mode;
			spec_q <= spec_meta_q;
			ecc_ready <= ready_q;
			single_error_irq <= irq_en_q & flag_q;
		end
	end

endmodule // sse_ecc

// ### inc/sse_regs.vh
// Register indices, field positions and reset values of the SECDED memory guard
`ifndef SSE_REGS_VH
`define SSE_REGS_VH

// Register indices; byte address on the bus is four times the index
`define SSE_IDX_STAT 4'h0
`define SSE_IDX_IRQ_EN 4'h1
`define SSE_IDX_FLAG 4'h2
`define SSE_IDX_PTR_H 4'h7
`define SSE_IDX_PTR_M 4'h8
`define SSE_IDX_PTR_L 4'h9
`define SSE_IDX_RAW_H 4'hC
`define SSE_IDX_RAW_L 4'hD
`define SSE_IDX_CHECK 4'hE
`define SSE_IDX_CMD 4'hF

// Field positions
`define SSE_RDY_BIT 0
`define SSE_IRQ_EN_BIT 0
`define SSE_FLAG_BIT 0
`define SSE_CMD_RD_BIT 0
`define SSE_CMD_WR_BIT 1
`define SSE_CMD_DONE_BIT 7

// Widths of the code
`define SSE_DATA_W 16
`define SSE_CHECK_W 6

// Reset values
`define SSE_RST_BIT 1'b0
`define SSE_RST_PTR 24'h000000
`define SSE_RST_RAW 16'h0000
`define SSE_RST_CHECK 6'h00

`endif

// ### src/sse_codec.v
// Combinational SECDED encoder and decoder for one 16-bit word with six check bits
`timescale 1ns/10ps

module sse_codec
(
	input wire [15:0] enc_data,
	output reg [5:0] enc_check,
	input wire [15:0] dec_data,
	input wire [5:0] dec_check,
	output reg [15:0] dec_fixed,
	output reg dec_single,
	output reg dec_double
);

	// Hamming positions 1..21; powers of two hold check bits, the rest data
	reg [21:1] enc_cw;
	reg [21:1] dec_cw;
	reg [4:0] syn;
	reg [4:0] pv;
	reg overall;
	integer p;
	integer i;
	integer j;
	// Encoder keeps its own loop variables so none has two drivers
	integer ep;
	integer ei;
	integer ej;

	// Encoder: five Hamming parities plus one overall parity
	always @*
	begin
		enc_cw = 21'h000000;
		enc_check = 6'h00;
		ej = 0;
		for (ep = 1; ep <= 21; ep = ep + 1)
		begin
			if ((ep & (ep - 1)) != 0)
			begin
				enc_cw[ep] = enc_data[ej];
				ej = ej + 1;
			end
		end
		for (ei = 0; ei < 5; ei = ei + 1)
		begin
			for (ep = 1; ep <= 21; ep = ep + 1)
			begin
				if (((ep >> ei) & 1) == 1)
					enc_check[ei] = enc_check[ei] ^ enc_cw[ep];
			end
		end
		enc_check[5] = (^enc_data) ^ (^enc_check[4:0]);
	end

	// Decoder: syndrome locates a single flip; overall parity tells one from two
	always @*
	begin
		dec_cw = 21'h000000;
		syn = 5'h00;
		pv = 5'h00;
		j = 0;
		for (p = 1; p <= 21; p = p + 1)
		begin
			if ((p & (p - 1)) != 0)
			begin
				dec_cw[p] = dec_data[j];
				j = j + 1;
			end
		end
		for (i = 0; i < 5; i = i + 1)
		begin
			syn[i] = dec_check[i];
			for (p = 1; p <= 21; p = p + 1)
			begin
				if (((p >> i) & 1) == 1)
					syn[i] = syn[i] ^ dec_cw[p];
			end
		end
		overall = (^dec_data) ^ (^dec_check);
		dec_single = overall;
		dec_double = ~overall & (syn != 5'h00);
		// Flip only on a single error; a double error leaves data untouched
		dec_fixed = dec_data;
		j = 0;
		for (p = 1; p <= 21; p = p + 1)
		begin
			if ((p & (p - 1)) != 0)
			begin
				pv = p[4:0];
				if (overall && (syn == pv))
					dec_fixed[j] = ~dec_data[j];
				j = j + 1;
			end
		end
	end

endmodule // sse_codec

// ### testbench/sse_ecc_asserts.sv
// Port-level concurrent checks of the SECDED memory guard
`timescale 1ns/10ps

module sse_ecc_chk
(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire sys_req,
	input wire sys_ack,
	input wire sys_single_err,
	input wire sys_double_err,
	input wire ecc_ready
);
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_pready_single: assert property (pready |=> !pready)
		else $error("pready held");
	chk_slverr_pair: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_ack_single: assert property (sys_ack |=> !sys_ack)
		else $error("ack held");
	chk_ack_has_req: assert property (sys_ack |-> sys_req)
		else $error("ack without request");
	chk_err_with_ack: assert property (sys_single_err || sys_double_err |-> sys_ack)
		else $error("error flag outside ack");
	chk_err_exclusive: assert property (!(sys_single_err && sys_double_err))
		else $error("both error flags");
	chk_ack_latency: assert property ($rose(sys_req) && ecc_ready |-> ##[2:12] sys_ack)
		else $error("request not answered");
	chk_init_blocks: assert property (!ecc_ready |-> !sys_ack)
		else $error("access during init");
	chk_ready_sticky: assert property (ecc_ready |=> ecc_ready)
		else $error("ready dropped");
endmodule // sse_ecc_chk

// ### testbench/sse_sysm.sv
// Behavioural system bus master on the protected memory port
`timescale 1ns/10ps

module sse_sysm
(
	input wire pclk,
	output logic sys_req,
	output logic sys_we,
	output logic [1:0] sys_be,
	output logic [3:0] sys_addr,
	output logic [15:0] sys_wdata,
	input wire sys_ack,
	input wire [15:0] sys_rdata,
	input wire sys_single_err,
	input wire sys_double_err
);
	// Idle bus at time zero
	initial
	begin
		sys_req = 1'b0;
		sys_we = 1'b0;
		sys_be = 2'b00;
		sys_addr = 4'h0;
		sys_wdata = 16'h0000;
	end

	// One transfer; the request stays unchanged until ack is sampled
	task acc(input logic we, input logic [1:0] be, input logic [3:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic se, output logic de);
		@(posedge pclk);
		sys_req <= 1'b1;
		sys_we <= we;
		sys_be <= be;
		sys_addr <= a;
		sys_wdata <= wd;
		// Ends when ack is sampled; no timeout here, a hang ends at the bench watchdog
		do @(posedge pclk); while (sys_ack !== 1'b1);
		se = sys_single_err;
		de = sys_double_err;
		// Uncorrectable data is thrown away, never passed on
		rd = de ? 16'h0000 : sys_rdata;
		sys_req <= 1'b0;
		// Released data must not look like a still valid value
		sys_wdata <= ~wd;
	endtask
endmodule // sse_sysm

// ### testbench/tb_top.sv
// Self-checking bench of the SECDED memory guard
`timescale 1ns/10ps

module tb_top;
	logic pclk, presetn, psel, penable, pwrite, special_mode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, seed;
	logic pready, pslverr, re, sys_req, sys_we, sys_ack, ss, sd, ecc_ready, irq, se, de;
	logic [1:0] sys_be;
	logic [3:0] sys_addr;
	logic [15:0] sys_wdata, sys_rdata, sr, m;
	logic [7:0] rh, rl, rc;
	logic [15:0] mem_m [16]; // Reference copy of the stored words
	int miscompares, compares, a, k;

	// Small memory keeps init short: 16 words
	sse_ecc #(.ADDR_W(4), .APB_AW(12)) sse_ecc_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .special_mode(special_mode),
		.sys_req(sys_req), .sys_we(sys_we), .sys_be(sys_be), .sys_addr(sys_addr),
		.sys_wdata(sys_wdata), .sys_ack(sys_ack), .sys_rdata(sys_rdata),
		.sys_single_err(ss), .sys_double_err(sd), .ecc_ready(ecc_ready),
		.single_error_irq(irq));
	sse_sysm sse_sysm_i (.pclk(pclk), .sys_req(sys_req), .sys_we(sys_we), .sys_be(sys_be),
		.sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
		.sys_rdata(sys_rdata), .sys_single_err(ss), .sys_double_err(sd));

	// 200 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	// APB transfer to register index i; byte address is four times the index
	task apb(input logic w, input logic [3:0] i, input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {6'h00, i, 2'b00};
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so the next setup never lands in the same time step
		@(posedge pclk);
	endtask

	// Raw fetch of word w into rh, rl, rc
	task dbg_rd(input logic [3:0] w);
		apb(1'b1, 4'h9, {3'b000, w, 1'b0});
		apb(1'b1, 4'hF, 8'h01);
		do apb(1'b0, 4'hF, 8'h00); while (rv[7] !== 1'b1);
		apb(1'b0, 4'hC, 8'h00);
		rh = rv[7:0];
		apb(1'b0, 4'hD, 8'h00);
		rl = rv[7:0];
		apb(1'b0, 4'hE, 8'h00);
		rc = rv[7:0];
	endtask

	// Corrupt stored data bits of word w by a raw debug write
	task flip(input logic [3:0] w, input logic [15:0] x);
		dbg_rd(w);
		apb(1'b1, 4'hC, rh ^ x[15:8]);
		apb(1'b1, 4'hD, rl ^ x[7:0]);
		apb(1'b1, 4'hF, 8'h02);
	endtask

	task sread(input logic [3:0] w, input logic es, input logic ed);
		sse_sysm_i.acc(1'b0, 2'b00, w, 16'h0000, sr, se, de);
		if (!ed)
			chk("rdata", mem_m[w], sr);
		chk("single", es, se);
		chk("double", ed, de);
	endtask

	task test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Watchdog well beyond the expected few hundred cycles
	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		test_done;
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		special_mode = 1'b1;
		seed = 32'h2B5FDA86;
		foreach (mem_m[i]) mem_m[i] = 16'h0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		while (ecc_ready !== 1'b1) @(posedge pclk);
		apb(1'b0, 4'h0, 8'h00);
		chk("ready", 1, rv);
		chk("ecc_ready", 1, ecc_ready);
		apb(1'b0, 4'h1, 8'h00);
		chk("irq_en", 0, rv);
		apb(1'b0, 4'h2, 8'h00);
		chk("flag", 0, rv);
		apb(1'b0, 4'h3, 8'h00);
		chk("reserved", 1, re);
		// Pointer bits beyond a 16-word span are not writeable
		apb(1'b1, 4'h7, 8'hFF);
		apb(1'b0, 4'h7, 8'h00);
		chk("ptr_high", 0, rv);
		apb(1'b1, 4'h9, 8'hFF);
		apb(1'b0, 4'h9, 8'h00);
		chk("ptr_low", 32'h0000001E, rv);
		dbg_rd(4'h3);
		chk("raw_init", 0, {rh, rl, rc});
		$display("test registers done");
		for (k = 0; k < 8; k++)
		begin
			seed = xs(seed);
			a = seed[3:0];
			mem_m[a] = seed[31:16];
			sse_sysm_i.acc(1'b1, 2'b11, seed[3:0], seed[31:16], sr, se, de);
		end
		for (a = 0; a < 16; a++)
			sread(a[3:0], 1'b0, 1'b0);
		$display("test full words done");
		seed = xs(seed);
		flip(4'h5, 16'h0001 << seed[3:0]);
		sread(4'h5, 1'b1, 1'b0);
		apb(1'b0, 4'h2, 8'h00);
		chk("flag", 1, rv);
		chk("irq", 0, irq);
		sread(4'h0, 1'b0, 1'b0);
		apb(1'b1, 4'h1, 8'h01);
		apb(1'b0, 4'h2, 8'h00);
		chk("flag", 1, rv);
		chk("irq", 1, irq);
		apb(1'b1, 4'h2, 8'h01);
		apb(1'b0, 4'h2, 8'h00);
		chk("flag", 0, rv);
		chk("irq", 0, irq);
		$display("test single error done");
		seed = xs(seed);
		m = 16'h0003 << (seed[3:0] % 15);
		flip(4'h9, m);
		sread(4'h9, 1'b0, 1'b1);
		dbg_rd(4'h9);
		chk("raw_kept", mem_m[9] ^ m, {rh, rl});
		seed = xs(seed);
		mem_m[9] = seed[15:0];
		sse_sysm_i.acc(1'b1, 2'b11, 4'h9, seed[15:0], sr, se, de);
		sread(4'h9, 1'b0, 1'b0);
		$display("test double error done");
		flip(4'hC, 16'h0100 << seed[18:16]);
		seed = xs(seed);
		mem_m[12][7:0] = seed[7:0];
		sse_sysm_i.acc(1'b1, 2'b01, 4'hC, seed[15:0], sr, se, de);
		sread(4'hC, 1'b0, 1'b0);
		apb(1'b0, 4'h2, 8'h00);
		chk("flag", 1, rv);
		$display("test byte write done");
		// With the strap low a read command is ignored; read-done stays set
		special_mode <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b1, 4'hF, 8'h01);
		apb(1'b0, 4'hF, 8'h00);
		chk("cmd_locked", 32'h00000080, rv);
		$display("test special mode done");
		test_done;
	end
endmodule // tb_top

bind sse_ecc sse_ecc_chk sse_ecc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .sys_req(sys_req),
	.sys_ack(sys_ack), .sys_single_err(sys_single_err), .sys_double_err(sys_double_err),
	.ecc_ready(ecc_ready));
